// *** core/srs_pkg.sv ***
package srs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int TICK_PERIOD_US  = 32;
    localparam int TICK_CYCLES     = (TICK_PERIOD_US * 1000000) / CLK_PERIOD_PS;
    localparam int PLL_WAIT_MS     = 16;
    localparam int STAT_WAIT_MS    = 1;
    localparam int PLL_WAIT_TICKS  = (PLL_WAIT_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
    localparam int STAT_WAIT_TICKS = (STAT_WAIT_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
    localparam int MIN_STEP_TICKS  = 1;
    localparam int CHANGE_TICKS    = 2;
    localparam int TICK_CNT_W      = 16;
    localparam int STEP_CNT_W      = 10;
    localparam int SYNC_STAGES     = 2;

    // ------------------------------------------------------------
    // Reset values of the sequencing outputs
    // ------------------------------------------------------------
    localparam logic RST_PLANE_A   = 1'b0;
    localparam logic RST_PLANE_B   = 1'b0;
    localparam logic RST_SLEEP     = 1'b0;
    localparam logic RST_HALT      = 1'b0;
    localparam logic RST_REQ       = 1'b0;
    localparam logic RST_STATUS    = 1'b0;
    localparam logic RST_CPU_RESET = 1'b1;
    localparam logic RST_BUS_RESET = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RESUME_CPU_RESET,
        RESUME_NO_RESET,
        RESUME_RAM
    } srs_resume_e;

    // Outputs held active high; pins other than processor reset and change allowed are inverted at the top
    typedef struct packed {
        logic plane_a;
        logic plane_b;
        logic sleep;
        logic halt;
        logic req;
        logic req_float;
        logic status;
        logic cpu_reset;
        logic bus_reset;
        logic change_ok;
    } srs_out_s;

    typedef struct packed {
        logic suspend_req;
        logic resume_event;
        logic stop_grant_done;
        logic power_good;
        logic clock_ctrl_en;
        logic ram_mode;
        logic no_reset_mode;
    } srs_in_s;

endpackage

// *** core/srs_sync.sv ***
`timescale 1ns/1ps
module srs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    import srs_pkg::*;

    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= '0;
            q          <= '0;
        end else begin
            stage1_reg <= d;
            q          <= stage1_reg;
        end
    end
endmodule

// *** core/srs_sequencer.sv ***
// Function
// - Steps timed by 32 us tick; change allowed drops at the suspend request without waiting for a tick
// - Plane A off one tick after resume
// - CPU-reset resume: reset on, sleep/halt off after tick
// - Requests off after 16 ms and power-good
// - Status off 1 ms after requests off
// - Requests may change within tick after status
// - Processor reset released within two ticks
// - No-reset resume: sleep off within tick
// - Halt off within tick after sleep
// - Halt on one tick after suspend request
// - Sleep after halt tick and stop-grant
// - Status on within tick after sleep
// - Requests on within tick, if clock control
// - Plane A on within tick, plane B too in RAM mode
// - Power-good loss while suspended in RAM mode: float, resets, sleep/halt off
// - Outputs held while power-good stays active
// - RAM resume: planes off after tick
`timescale 1ns/1ps
module srs_sequencer #(
    parameter int TICK_DIV     = srs_pkg::TICK_CYCLES,
    parameter int PLL_TICKS    = srs_pkg::PLL_WAIT_TICKS,
    parameter int STAT_TICKS   = srs_pkg::STAT_WAIT_TICKS
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // Requests from the system, all asynchronous
    input  wire logic SUSPEND_REQ,
    input  wire logic RESUME_EVENT,
    input  wire logic STOP_GRANT_DONE,
    input  wire logic CLOCK_CTRL_EN,
    input  wire logic RAM_MODE,
    input  wire logic NO_RESET_MODE,
    // Power supply
    input  wire logic POWER_GOOD_IN,
    output logic      SUSPEND_PLANE_A_CTRL_N,
    output logic      SUSPEND_PLANE_B_CTRL_N,
    // Processor
    output logic      PROCESSOR_RESET_OUT,
    output logic      PROCESSOR_SLEEP_OUT_N,
    output logic      PROCESSOR_CLOCK_HALT_OUT_N,
    // Clock synthesizer, open drain style
    output logic      BUS_CLOCK_HALT_REQ_N_O,
    output logic      BUS_CLOCK_HALT_REQ_N_OE,
    output logic      CORE_CLOCK_HALT_REQ_N_O,
    output logic      CORE_CLOCK_HALT_REQ_N_OE,
    // System
    output logic      SUSPEND_STATE_FLAGS_N,
    output logic      BUS_RESET_LINE_N,
    output logic      CHANGE_ALLOWED,
    output logic      SUSPENDED
);
    import srs_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    srs_in_s raw_in;
    srs_in_s sync_in;

    assign raw_in = '{suspend_req:     SUSPEND_REQ,
                      resume_event:    RESUME_EVENT,
                      stop_grant_done: STOP_GRANT_DONE,
                      power_good:      POWER_GOOD_IN,
                      clock_ctrl_en:   CLOCK_CTRL_EN,
                      ram_mode:        RAM_MODE,
                      no_reset_mode:   NO_RESET_MODE};

    srs_sync #(.WIDTH($bits(srs_in_s))) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   (raw_in),
        .q   (sync_in)
    );

    // ------------------------------------------------------------
    // Slow tick
    // ------------------------------------------------------------
    logic [TICK_CNT_W-1:0] div_reg;
    logic                  tick_reg;
    wire                   div_wrap = (div_reg == TICK_CNT_W'(TICK_DIV - 1));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_wrap ? '0 : div_reg + 1'b1;
            tick_reg <= div_wrap;
        end
    end

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_ON,
        ST_ENTER_HALT,
        ST_ENTER_SLEEP,
        ST_ENTER_STATUS,
        ST_ENTER_REQ,
        ST_ENTER_PLANES,
        ST_SUSPENDED,
        ST_RES_START,
        ST_RES_PLL,
        ST_RES_STATUS,
        ST_RES_FINISH,
        ST_RES_HALT,
        ST_POWER_LOST
    } srs_state_e;

    srs_state_e            state_reg, state_next;
    srs_resume_e           mode_reg, mode_next;
    srs_out_s              out_reg, out_next;
    logic [STEP_CNT_W-1:0] step_reg, step_next;
    logic                  pg_seen_reg, pg_seen_next;

    wire pg        = sync_in.power_good;
    wire step_tick = tick_reg;
    wire pll_done  = (step_reg >= STEP_CNT_W'(PLL_TICKS));
    wire stat_done = (step_reg >= STEP_CNT_W'(STAT_TICKS));
    wire one_done  = (step_reg >= STEP_CNT_W'(MIN_STEP_TICKS));
    // Acts once per loss; a floated request marks the loss as handled
    wire lose_pg   = !pg && (state_reg == ST_SUSPENDED) && mode_reg == RESUME_RAM
                     && !out_reg.req_float;

    always_comb begin
        state_next   = state_reg;
        mode_next    = mode_reg;
        out_next     = out_reg;
        // Saturates so a long power-good wait cannot wrap the count
        step_next    = (step_tick && !(&step_reg)) ? step_reg + 1'b1 : step_reg;
        pg_seen_next = pg_seen_reg;
        if (lose_pg) begin
            // Wait a tick boundary, then float and reset
            state_next = ST_POWER_LOST;
            step_next  = '0;
        end else begin
            unique case (state_reg)
                ST_ON: begin
                    out_next.change_ok = 1'b1;
                    if (sync_in.suspend_req) begin
                        mode_next = sync_in.ram_mode ? RESUME_RAM :
                                    sync_in.no_reset_mode ? RESUME_NO_RESET
                                                          : RESUME_CPU_RESET;
                        out_next.change_ok = 1'b0;
                        state_next = ST_ENTER_HALT;
                        step_next  = '0;
                    end
                end
                ST_ENTER_HALT: if (step_tick && one_done) begin
                    out_next.halt = 1'b1;
                    state_next    = ST_ENTER_SLEEP;
                    step_next     = '0;
                end
                ST_ENTER_SLEEP: if (step_tick && one_done && sync_in.stop_grant_done) begin
                    out_next.sleep = 1'b1;
                    state_next     = ST_ENTER_STATUS;
                    step_next      = '0;
                end
                ST_ENTER_STATUS: if (step_tick) begin
                    out_next.status = 1'b1;
                    state_next      = ST_ENTER_REQ;
                    step_next       = '0;
                end
                ST_ENTER_REQ: if (step_tick) begin
                    out_next.req = sync_in.clock_ctrl_en;
                    state_next   = ST_ENTER_PLANES;
                    step_next    = '0;
                end
                ST_ENTER_PLANES: if (step_tick) begin
                    out_next.plane_a = 1'b1;
                    out_next.plane_b = (mode_reg == RESUME_RAM);
                    state_next       = ST_SUSPENDED;
                    step_next        = '0;
                end
                ST_SUSPENDED: if (sync_in.resume_event) begin
                    // Outputs held until resume
                    state_next = ST_RES_START;
                    step_next  = '0;
                end
                ST_RES_START: if (step_tick && one_done) begin
                    out_next.plane_a = 1'b0;
                    out_next.plane_b = 1'b0;
                    if (mode_reg == RESUME_CPU_RESET) begin
                        out_next.cpu_reset = 1'b1;
                        out_next.sleep     = 1'b0;
                        out_next.halt      = 1'b0;
                    end
                    pg_seen_next = 1'b0;
                    state_next   = ST_RES_PLL;
                    step_next    = '0;
                end
                ST_RES_PLL: begin
                    // Core power returns in RAM mode; power-good then rises
                    if (step_tick && pg) begin
                        pg_seen_next = 1'b1;
                    end
                    if (step_tick && pll_done && pg_seen_reg && pg) begin
                        out_next.req       = 1'b0;
                        out_next.req_float = 1'b0;
                        state_next         = ST_RES_STATUS;
                        step_next          = '0;
                    end
                end
                ST_RES_STATUS: if (step_tick && stat_done) begin
                    out_next.status = 1'b0;
                    state_next      = ST_RES_FINISH;
                    step_next       = '0;
                end
                ST_RES_FINISH: if (step_tick) begin
                    out_next.change_ok = 1'b1;
                    out_next.bus_reset = 1'b0;
                    if (mode_reg == RESUME_NO_RESET) begin
                        out_next.sleep = 1'b0;
                        state_next     = ST_RES_HALT;
                    end else begin
                        out_next.cpu_reset = 1'b0;
                        out_next.sleep     = 1'b0;
                        out_next.halt      = 1'b0;
                        state_next         = ST_ON;
                    end
                    step_next = '0;
                end
                ST_RES_HALT: if (step_tick) begin
                    out_next.halt = 1'b0;
                    state_next    = ST_ON;
                    step_next     = '0;
                end
                ST_POWER_LOST: begin
                    if (step_tick) begin
                        out_next.req_float = 1'b1;
                        out_next.req       = 1'b0;
                        out_next.bus_reset = 1'b1;
                        out_next.cpu_reset = 1'b1;
                        out_next.sleep     = 1'b0;
                        out_next.halt      = 1'b0;
                        state_next         = ST_SUSPENDED;
                        step_next          = '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg   <= ST_ON;
            mode_reg    <= RESUME_CPU_RESET;
            step_reg    <= '0;
            pg_seen_reg <= 1'b0;
            out_reg     <= '{plane_a: RST_PLANE_A, plane_b: RST_PLANE_B,
                             sleep: RST_SLEEP, halt: RST_HALT, req: RST_REQ,
                             req_float: 1'b0, status: RST_STATUS,
                             cpu_reset: RST_CPU_RESET, bus_reset: RST_BUS_RESET,
                             change_ok: 1'b0};
        end else begin
            state_reg   <= state_next;
            mode_reg    <= mode_next;
            step_reg    <= step_next;
            pg_seen_reg <= pg_seen_next;
            out_reg     <= out_next;
        end
    end

    // ------------------------------------------------------------
    // Pin registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SUSPEND_PLANE_A_CTRL_N     <= 1'b1;
            SUSPEND_PLANE_B_CTRL_N     <= 1'b1;
            PROCESSOR_RESET_OUT        <= 1'b1;
            PROCESSOR_SLEEP_OUT_N      <= 1'b1;
            PROCESSOR_CLOCK_HALT_OUT_N <= 1'b1;
            BUS_CLOCK_HALT_REQ_N_O     <= 1'b1;
            BUS_CLOCK_HALT_REQ_N_OE    <= 1'b1;
            CORE_CLOCK_HALT_REQ_N_O    <= 1'b1;
            CORE_CLOCK_HALT_REQ_N_OE   <= 1'b1;
            SUSPEND_STATE_FLAGS_N      <= 1'b1;
            BUS_RESET_LINE_N           <= 1'b0;
            CHANGE_ALLOWED             <= 1'b0;
            SUSPENDED                  <= 1'b0;
        end else begin
            SUSPEND_PLANE_A_CTRL_N     <= !out_next.plane_a;
            SUSPEND_PLANE_B_CTRL_N     <= !out_next.plane_b;
            PROCESSOR_RESET_OUT        <= out_next.cpu_reset;
            PROCESSOR_SLEEP_OUT_N      <= !out_next.sleep;
            PROCESSOR_CLOCK_HALT_OUT_N <= !out_next.halt;
            BUS_CLOCK_HALT_REQ_N_O     <= !out_next.req;
            BUS_CLOCK_HALT_REQ_N_OE    <= !out_next.req_float;
            CORE_CLOCK_HALT_REQ_N_O    <= !out_next.req;
            CORE_CLOCK_HALT_REQ_N_OE   <= !out_next.req_float;
            SUSPEND_STATE_FLAGS_N      <= !out_next.status;
            BUS_RESET_LINE_N           <= !out_next.bus_reset;
            CHANGE_ALLOWED             <= out_next.change_ok;
            SUSPENDED                  <= (state_next == ST_SUSPENDED);
        end
    end
endmodule

// *** test/srs_sequencer_props.sv ***
`timescale 1ns/1ps
module srs_sequencer_props #(
    parameter int TICK_DIV   = 4,
    parameter int PLL_TICKS  = 3,
    parameter int STAT_TICKS = 2
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SUSPEND_REQ,
    input wire logic RESUME_EVENT,
    input wire logic STOP_GRANT_DONE,
    input wire logic CLOCK_CTRL_EN,
    input wire logic POWER_GOOD_IN,
    input wire logic SUSPEND_PLANE_A_CTRL_N,
    input wire logic SUSPEND_PLANE_B_CTRL_N,
    input wire logic PROCESSOR_RESET_OUT,
    input wire logic PROCESSOR_SLEEP_OUT_N,
    input wire logic PROCESSOR_CLOCK_HALT_OUT_N,
    input wire logic BUS_CLOCK_HALT_REQ_N_O,
    input wire logic BUS_CLOCK_HALT_REQ_N_OE,
    input wire logic CORE_CLOCK_HALT_REQ_N_O,
    input wire logic CORE_CLOCK_HALT_REQ_N_OE,
    input wire logic SUSPEND_STATE_FLAGS_N,
    input wire logic BUS_RESET_LINE_N,
    input wire logic SUSPENDED
);
    localparam int WIN      = TICK_DIV + 1;
    localparam int W2       = 2 * TICK_DIV + 1;
    localparam int W3       = TICK_DIV + 4;
    localparam int PLL_CYC  = PLL_TICKS * TICK_DIV;
    localparam int STAT_CYC = STAT_TICKS * TICK_DIV;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    sequence s_stat_off;
        $rose(SUSPEND_STATE_FLAGS_N);
    endsequence
    sequence s_pg_lost;
        $fell(POWER_GOOD_IN) && SUSPENDED && !SUSPEND_PLANE_B_CTRL_N;
    endsequence
    property p_plane_hold;
        $rose(RESUME_EVENT) && SUSPENDED |-> !SUSPEND_PLANE_A_CTRL_N [*4];
    endproperty
    property p_req_off;
        $rose(BUS_CLOCK_HALT_REQ_N_O) && BUS_CLOCK_HALT_REQ_N_OE
            |-> $past(SUSPEND_PLANE_A_CTRL_N, PLL_CYC);
    endproperty
    property p_flags_off;
        s_stat_off |-> $past(BUS_CLOCK_HALT_REQ_N_O, STAT_CYC);
    endproperty
    property p_cpu_rel;
        s_stat_off ##0 PROCESSOR_RESET_OUT |-> ##[1:W2] !PROCESSOR_RESET_OUT;
    endproperty
    property p_sleep_off;
        s_stat_off ##0 !PROCESSOR_SLEEP_OUT_N |-> ##[1:WIN] PROCESSOR_SLEEP_OUT_N;
    endproperty
    property p_halt_off;
        $rose(PROCESSOR_SLEEP_OUT_N) && !PROCESSOR_CLOCK_HALT_OUT_N
            |-> ##[1:WIN] PROCESSOR_CLOCK_HALT_OUT_N;
    endproperty
    property p_halt_on;
        $fell(PROCESSOR_CLOCK_HALT_OUT_N) |-> $past(SUSPEND_REQ, TICK_DIV);
    endproperty
    property p_sleep_on;
        $fell(PROCESSOR_SLEEP_OUT_N)
            |-> !$past(PROCESSOR_CLOCK_HALT_OUT_N, TICK_DIV) && $past(STOP_GRANT_DONE, 3);
    endproperty
    property p_status_on;
        $fell(PROCESSOR_SLEEP_OUT_N) |-> ##[1:WIN] $fell(SUSPEND_STATE_FLAGS_N);
    endproperty
    property p_req_on;
        $fell(SUSPEND_STATE_FLAGS_N) && CLOCK_CTRL_EN
            |-> ##[1:WIN] (!BUS_CLOCK_HALT_REQ_N_O && !CORE_CLOCK_HALT_REQ_N_O);
    endproperty
    property p_pg_cut;
        s_pg_lost |-> ##[1:W3] (!BUS_CLOCK_HALT_REQ_N_OE && !CORE_CLOCK_HALT_REQ_N_OE
            && PROCESSOR_RESET_OUT && !BUS_RESET_LINE_N
            && PROCESSOR_SLEEP_OUT_N && PROCESSOR_CLOCK_HALT_OUT_N);
    endproperty
    a_plane_hold: assert property (p_plane_hold) else $error("plane A off too early");
    a_req_off: assert property (p_req_off) else $error("requests off too early");
    a_flags_off: assert property (p_flags_off) else $error("flags off too early");
    a_cpu_rel: assert property (p_cpu_rel) else $error("cpu reset held");
    a_sleep_off: assert property (p_sleep_off) else $error("sleep held");
    a_halt_off: assert property (p_halt_off) else $error("halt held");
    a_halt_on: assert property (p_halt_on) else $error("halt without request");
    a_sleep_on: assert property (p_sleep_on) else $error("sleep too early");
    a_status_on: assert property (p_status_on) else $error("flags late");
    a_req_on: assert property (p_req_on) else $error("requests late");
    a_pg_cut: assert property (p_pg_cut) else $error("power loss response late");
endmodule

bind srs_sequencer srs_sequencer_props #(
    .TICK_DIV(TICK_DIV),
    .PLL_TICKS(PLL_TICKS),
    .STAT_TICKS(STAT_TICKS)
) u_props (.*);

// *** test/srs_partner.sv ***
`timescale 1ns/1ps
module srs_partner #(
    parameter int PG_DLY = 40
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic halt_n,
    input  wire logic plane_a_n,
    input  wire logic plane_b_n,
    input  wire logic bus_req_n,
    input  wire logic core_req_n,
    input  wire logic pwr_off,
    output logic      grant,
    output logic      power_good,
    output logic      clocks_run
);
    int   pg_cnt;
    logic core_on;
    // ------------------------------------------------------------
    // Processor, supply and synthesizer
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            grant   <= 1'b0;
            core_on <= 1'b1;
            pg_cnt  <= PG_DLY;
        end else begin
            grant <= !halt_n;
            if (pwr_off && !plane_a_n && !plane_b_n) begin
                core_on <= 1'b0;
            end else if (!pwr_off) begin
                core_on <= 1'b1;
            end
            pg_cnt <= !core_on ? 0 : (pg_cnt < PG_DLY ? pg_cnt + 1 : pg_cnt);
        end
    end
    assign power_good = core_on && (pg_cnt >= PG_DLY);
    assign clocks_run = bus_req_n && core_req_n;
endmodule

// *** test/suspend_resume_sequencer_test.sv ***
`timescale 1ns/1ps
module suspend_resume_sequencer_test;
    localparam int TD     = 4;
    localparam int PLL    = 3;
    localparam int ST     = 2;
    localparam int PG_DLY = 40;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic susp_req = 1'b0;
    logic res_ev = 1'b0;
    logic ctrl_en = 1'b1;
    logic ram = 1'b0;
    logic nores = 1'b0;
    logic pwr_off = 1'b0;
    logic grant, pgood, pa_n, pb_n, cpu_rst, slp_n, hlt_n;
    logic bo, boe, co, coe, flg_n, brst_n, chg, susp;
    wire  bus_req_n  = boe ? bo : 1'b1;
    wire  core_req_n = coe ? co : 1'b1;
    wire [10:0] outs = {pa_n, pb_n, cpu_rst, slp_n, hlt_n, bus_req_n, core_req_n,
                        flg_n, brst_n, chg, susp};
    int mismatches = 0;
    int samples_checked = 0;
    int n;
    int m;
    srs_sequencer #(.TICK_DIV(TD), .PLL_TICKS(PLL), .STAT_TICKS(ST)) DUT (
        .CLK(clk), .RST(rst), .SUSPEND_REQ(susp_req), .RESUME_EVENT(res_ev),
        .STOP_GRANT_DONE(grant), .CLOCK_CTRL_EN(ctrl_en), .RAM_MODE(ram),
        .NO_RESET_MODE(nores), .POWER_GOOD_IN(pgood), .SUSPEND_PLANE_A_CTRL_N(pa_n),
        .SUSPEND_PLANE_B_CTRL_N(pb_n), .PROCESSOR_RESET_OUT(cpu_rst),
        .PROCESSOR_SLEEP_OUT_N(slp_n), .PROCESSOR_CLOCK_HALT_OUT_N(hlt_n),
        .BUS_CLOCK_HALT_REQ_N_O(bo), .BUS_CLOCK_HALT_REQ_N_OE(boe),
        .CORE_CLOCK_HALT_REQ_N_O(co), .CORE_CLOCK_HALT_REQ_N_OE(coe),
        .SUSPEND_STATE_FLAGS_N(flg_n), .BUS_RESET_LINE_N(brst_n),
        .CHANGE_ALLOWED(chg), .SUSPENDED(susp));
    srs_partner #(.PG_DLY(PG_DLY)) u_partner (
        .clk(clk), .rst(rst), .halt_n(hlt_n), .plane_a_n(pa_n), .plane_b_n(pb_n),
        .bus_req_n(bus_req_n), .core_req_n(core_req_n), .pwr_off(pwr_off),
        .grant(grant), .power_good(pgood), .clocks_run());
    initial begin
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Compare, wait and closing tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("MISMATCH t=%0t cycles=%h range=%h..%h", $time, got, lo, hi);
        end
    endtask
    function automatic logic pick(input int sel);
        return sel == 0 ? susp : (sel == 1 ? chg : pa_n);
    endfunction
    task automatic wait_on(input int sel, output int cyc);
        cyc = 0;
        while (pick(sel) !== 1'b1 && cyc < 2000) begin
            @(negedge clk);
            cyc++;
        end
        if (cyc >= 2000) begin
            mismatches++;
            $display("MISMATCH t=%0t timeout got=%h exp=%h", $time, sel, 1);
            end_sim();
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        repeat (10) @(negedge clk);
        chk(outs, 11'h7F8);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(outs, 11'h7FA);
        res_ev = 1'b1;
        repeat (4 * TD) @(negedge clk);
        res_ev = 1'b0;
        chk(outs, 11'h7FA);
        $display("t_reset done");
    endtask
    task automatic t_enter(input logic ram_i, input logic ctrl_i, input logic nores_i);
        ram = ram_i;
        ctrl_en = ctrl_i;
        nores = nores_i;
        susp_req = 1'b1;
        wait_on(0, n);
        susp_req = 1'b0;
        chk_rng(n, 5 * TD, 8 * TD);
        repeat (10 * TD) @(negedge clk);
        chk({4'h0, pa_n, pb_n, slp_n, hlt_n, bus_req_n, core_req_n, flg_n},
            {4'h0, 1'b0, !ram_i, 2'b00, !ctrl_i, !ctrl_i, 1'b0});
        $display("t_enter done");
    endtask
    task automatic t_resume(input logic nores_i);
        res_ev = 1'b1;
        wait_on(2, n);
        chk({8'h00, cpu_rst, slp_n, hlt_n}, nores_i ? 11'h000 : 11'h007);
        wait_on(1, m);
        res_ev = 1'b0;
        chk_rng(n + m, (1 + PLL + ST) * TD, (6 + PLL + ST) * TD);
        repeat (2 * TD) @(negedge clk);
        chk(outs, 11'h6FE);
        $display("t_resume done");
    endtask
    task automatic t_ram_loss;
        pwr_off = 1'b1;
        repeat (3 * TD) @(negedge clk);
        chk({5'h00, boe, coe, cpu_rst, brst_n, slp_n, hlt_n}, 11'h00B);
        res_ev = 1'b1;
        wait_on(2, n);
        pwr_off = 1'b0;
        wait_on(1, n);
        res_ev = 1'b0;
        chk_rng(n, PG_DLY + (ST + 1) * TD, PG_DLY + (ST + 5) * TD);
        repeat (2 * TD) @(negedge clk);
        chk({outs[10:1], boe & coe}, 11'h6FF);
        $display("t_ram_loss done");
    endtask
    initial begin
        t_reset();
        t_enter(1'b0, 1'b1, 1'b0);
        t_resume(1'b0);
        t_enter(1'b0, 1'b0, 1'b1);
        t_resume(1'b1);
        t_enter(1'b1, 1'b1, 1'b0);
        t_ram_loss();
        end_sim();
    end
endmodule
